// file: logic/dhba_map.svh
// address map, bit positions and timing counts of the disk host bus adapter
`ifndef DHBA_MAP_SVH
`define DHBA_MAP_SVH

// slot-decoded register window: base plus slot number times sixteen
`define DHBA_DEVSEL_BASE  16'hC080
`define DHBA_OFS_DATA     4'h0
`define DHBA_OFS_CTRL     4'h1

// slot page and shared expansion area
`define DHBA_SLOT_PAGE_HI 8'hC0
`define DHBA_EXP_HI5      5'h19
`define DHBA_EXP_OFF      16'hCFFF
`define DHBA_PROM_WORDS   2048
`define DHBA_PROM_AW      11

// control port bits
`define DHBA_CTL_SEL_BIT  7
`define DHBA_CTL_BSY_BIT  6
`define DHBA_CTL_RST_BIT  5

// value driven on the controller data bus while selecting
`define DHBA_SEL_ID       8'h01
// status bits 2 and 1 read high
`define DHBA_ST_ONES      2'h3

// reset pulse ceiling: time in ms, clock in kHz, count rounds down
`define DHBA_CLK_KHZ      25000
`define DHBA_RST_MAX_MS   5000
`define DHBA_RST_MAX_CYC  (`DHBA_RST_MAX_MS * `DHBA_CLK_KHZ)
`define DHBA_RST_CW       27

// synchroniser width: slot 3, data 8, parity, req, cd, io, msg, busy
`define DHBA_SYNC_W       17

`endif

// file: logic/dhba_pkg.sv
// types shared by the disk host bus adapter
package dhba_pkg;

	// controller-side byte handshake
	typedef enum logic [1:0] {
		HS_IDLE,
		HS_SETUP,
		HS_ACK
	} dhba_hs_t;

	// what a slot bus address hits
	typedef enum logic [2:0] {
		RG_NONE,
		RG_DATA,
		RG_CTRL,
		RG_SLOTPG,
		RG_EXP,
		RG_EXPOFF
	} dhba_region_t;

endpackage : dhba_pkg

// file: logic/dhba_sync.sv
// two-flop synchroniser for all pins coming in from the controller bus
`timescale 1ns/1ps
`default_nettype none
`include "dhba_map.svh"

module dhba_sync (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic [`DHBA_SYNC_W-1:0] d_i,
	output logic      [`DHBA_SYNC_W-1:0] q_o
);
	logic [`DHBA_SYNC_W-1:0] meta_reg; // first stage, read only by the second

	// both stages clear on reset so no stale REQ is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			q_o      <= '0;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule : dhba_sync
`default_nettype wire

// file: logic/dhba_top.sv
// programmed-i/o adapter between a wishbone slot bus and a parallel disk controller bus
`timescale 1ns/1ps
`default_nettype none
`include "dhba_map.svh"

module dhba_top
	import dhba_pkg::*;
#(
	parameter int unsigned RST_MAX_CYC = `DHBA_RST_MAX_CYC // reset pulse ceiling in cycles
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] wb_adr_i,
	input  wire logic [7:0]  wb_dat_i,
	output logic      [7:0]  wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [0:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	input  wire logic [2:0]  slot_num_i,
	input  wire logic        prom_load_we_i,
	input  wire logic [10:0] prom_load_adr_i,
	input  wire logic [7:0]  prom_load_dat_i,
	input  wire logic [7:0]  ctl_data_i,
	input  wire logic        ctl_par_i,
	input  wire logic        ctl_req_i,
	input  wire logic        ctl_cd_i,
	input  wire logic        ctl_io_i,
	input  wire logic        ctl_msg_i,
	input  wire logic        ctl_busy_i,
	output logic      [7:0]  ctl_data_o,
	output logic             ctl_data_oe_o,
	output logic             ctl_par_o,
	output logic             ctl_sel_o,
	output logic             ctl_bsy_o,
	output logic             ctl_rst_o,
	output logic             ctl_ack_o
);

	////////////////////////////////////////////////////////////////////////////////
	// address decode shared by the bus logic and the checks

	function automatic dhba_region_t dhba_decode(input logic [15:0] adr, input logic [2:0] slot);
		logic [15:0] win;
		win = `DHBA_DEVSEL_BASE + {8'h00, 1'b0, slot, 4'h0};
		dhba_decode = RG_NONE;
		if (adr[15:4] == win[15:4]) begin
			if (adr[3:0] == `DHBA_OFS_DATA)
				dhba_decode = RG_DATA;
			else if (adr[3:0] == `DHBA_OFS_CTRL)
				dhba_decode = RG_CTRL;
		end else if (slot != 3'h0 && adr[15:8] == (`DHBA_SLOT_PAGE_HI | {5'h00, slot})) begin
			dhba_decode = RG_SLOTPG;
		end else if (adr == `DHBA_EXP_OFF) begin
			dhba_decode = RG_EXPOFF;
		end else if (adr[15:11] == `DHBA_EXP_HI5) begin
			dhba_decode = RG_EXP;
		end
	endfunction : dhba_decode

	////////////////////////////////////////////////////////////////////////////////
	// synchronised controller pins and slot strap

	logic [`DHBA_SYNC_W-1:0] sync_q;           // synchronised bundle
	logic [2:0]              slot_s;           // slot number
	logic [7:0]              data_s;           // inbound data byte
	logic                    par_s;            // inbound parity
	logic                    req_s;            // REQ
	logic                    cd_s;             // command/data
	logic                    io_s;             // direction, high toward controller
	logic                    msg_s;            // last byte
	logic                    busy_s;           // controller busy

	dhba_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({slot_num_i, ctl_data_i, ctl_par_i, ctl_req_i, ctl_cd_i, ctl_io_i,
		         ctl_msg_i, ctl_busy_i}),
		.q_o   (sync_q)
	);

	assign {slot_s, data_s, par_s, req_s, cd_s, io_s, msg_s, busy_s} = sync_q;

	////////////////////////////////////////////////////////////////////////////////
	// expansion prom, loaded through its own programming port

	logic [7:0]               prom_mem [0:`DHBA_PROM_WORDS-1]; // 2K bytes
	logic [`DHBA_PROM_AW-1:0] prom_adr;                         // read address
	logic [7:0]               prom_q;                           // read data

	// write-only load port, kept off the slot bus like a socketed part
	always_ff @(posedge clk_i) begin
		if (prom_load_we_i)
			prom_mem[prom_load_adr_i] <= prom_load_dat_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state and next values

	logic                   ack_reg,  ack_next;      // wishbone ack
	logic [7:0]             rdat_reg, rdat_next;     // wishbone read data
	logic                   sel_reg,  sel_next;      // control bit 7
	logic                   bsy_reg,  bsy_next;      // control bit 6
	logic                   rst_reg,  rst_next;      // control bit 5
	logic [`DHBA_RST_CW-1:0] rcnt_reg, rcnt_next;    // reset pulse length
	logic                   pen_reg,  pen_next;      // expansion prom enable
	logic [7:0]             hold_reg, hold_next;     // outbound holding byte
	dhba_hs_t               hs_reg,   hs_next;       // controller handshake
	logic [7:0]             dout_reg, dout_next;     // controller data out
	logic                   doe_reg,  doe_next;      // controller data enable
	logic                   par_reg,  par_next;      // outbound odd parity
	logic                   cack_reg, cack_next;     // controller ACK
	logic                   bus_req;                 // new slot bus request
	logic                   wr;                      // request is a write
	logic                   dp_go;                   // data access starting a byte cycle
	dhba_region_t           rg;                      // decoded region

	// bus slave, control port, prom enable and handshake
	always_comb begin
		bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
		rg        = dhba_decode(wb_adr_i, slot_s);
		wr        = bus_req & wb_we_i & wb_sel_i[0];
		prom_adr  = (rg == RG_SLOTPG) ? {3'h0, wb_adr_i[7:0]} : wb_adr_i[10:0];
		prom_q    = prom_mem[prom_adr];
		ack_next  = bus_req; // one wait state, unmapped addresses answer too
		rdat_next = rdat_reg;
		sel_next  = sel_reg;
		bsy_next  = bsy_reg;
		rst_next  = rst_reg;
		rcnt_next = '0;
		pen_next  = pen_reg;
		hold_next = hold_reg;
		hs_next   = hs_reg;
		dp_go     = bus_req & (rg == RG_DATA) & req_s & (hs_reg == HS_IDLE) &
		            (~wb_we_i | wb_sel_i[0]);
		if (bus_req && !wb_we_i) begin
			case (rg)
				RG_DATA:   rdat_next = data_s;
				RG_CTRL:   rdat_next = {req_s, cd_s, io_s, msg_s, busy_s, `DHBA_ST_ONES,
				                        ^{data_s, par_s}};
				RG_SLOTPG: rdat_next = prom_q;
				RG_EXP:    rdat_next = pen_reg ? prom_q : 8'h00;
				default:   rdat_next = 8'h00;
			endcase
		end
		// control bits are write only; reads of this port return status
		if (wr && rg == RG_CTRL) begin
			sel_next = wb_dat_i[`DHBA_CTL_SEL_BIT];
			bsy_next = wb_dat_i[`DHBA_CTL_BSY_BIT];
			rst_next = wb_dat_i[`DHBA_CTL_RST_BIT];
		end
		// reset pulse self-terminates so a stuck driver cannot exceed the ceiling
		if (rst_reg) begin
			rcnt_next = rcnt_reg + `DHBA_RST_CW'(1);
			if (rcnt_reg == `DHBA_RST_CW'(RST_MAX_CYC - 1)) begin
				rst_next  = 1'b0;
				rcnt_next = '0;
			end
		end
		// any slot page access enables, the CFFF access disables
		if (bus_req && rg == RG_SLOTPG)
			pen_next = 1'b1;
		else if (bus_req && rg == RG_EXPOFF)
			pen_next = 1'b0;
		// writes taken while a byte is still being acknowledged are dropped
		if (wr && rg == RG_DATA && hs_reg == HS_IDLE)
			hold_next = wb_dat_i;
		case (hs_reg)
			HS_IDLE:  if (dp_go) hs_next = HS_SETUP;
			HS_SETUP: hs_next = HS_ACK; // data settles one cycle before ACK
			HS_ACK:   if (!req_s) hs_next = HS_IDLE;
			default:  hs_next = HS_IDLE;
		endcase
		cack_next = (hs_next == HS_ACK);
		doe_next  = sel_next | (busy_s & io_s);
		dout_next = sel_next ? `DHBA_SEL_ID : hold_next;
		par_next  = ~^dout_next;
	end

	// register everything; outputs come straight from these
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 8'h00;
			sel_reg  <= 1'b0;
			bsy_reg  <= 1'b0;
			rst_reg  <= 1'b0;
			rcnt_reg <= '0;
			pen_reg  <= 1'b0;
			hold_reg <= 8'h00;
			hs_reg   <= HS_IDLE;
			dout_reg <= 8'h00;
			doe_reg  <= 1'b0;
			par_reg  <= 1'b1;
			cack_reg <= 1'b0;
		end else begin
			ack_reg  <= ack_next;
			rdat_reg <= rdat_next;
			sel_reg  <= sel_next;
			bsy_reg  <= bsy_next;
			rst_reg  <= rst_next;
			rcnt_reg <= rcnt_next;
			pen_reg  <= pen_next;
			hold_reg <= hold_next;
			hs_reg   <= hs_next;
			dout_reg <= dout_next;
			doe_reg  <= doe_next;
			par_reg  <= par_next;
			cack_reg <= cack_next;
		end
	end

	assign wb_ack_o      = ack_reg;
	assign wb_dat_o      = rdat_reg;
	assign ctl_sel_o     = sel_reg;
	assign ctl_bsy_o     = bsy_reg;
	assign ctl_rst_o     = rst_reg;
	assign ctl_data_o    = dout_reg;
	assign ctl_data_oe_o = doe_reg;
	assign ctl_par_o     = par_reg;
	assign ctl_ack_o     = cack_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_data_rd;
		bus_req && !wb_we_i && rg == RG_DATA |=> wb_dat_o == $past(data_s);
	endproperty
	a_data_rd: assert property (p_data_rd) else $error("data port read wrong");

	property p_unused_ofs;
		bus_req && !wb_we_i && rg == RG_NONE |=> wb_ack_o && wb_dat_o == 8'h00;
	endproperty
	a_unused_ofs: assert property (p_unused_ofs) else $error("unused address not zero");

	property p_ack_cause;
		$rose(ctl_ack_o) |-> $past(dp_go, 2);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ACK without byte cycle");

	property p_ack_hold;
		ctl_ack_o && req_s |=> ctl_ack_o;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ACK dropped under REQ");

	property p_out_byte;
		dp_go && wb_we_i |-> ##2 (ctl_sel_o || ctl_data_o == $past(wb_dat_i, 2));
	endproperty
	a_out_byte: assert property (p_out_byte) else $error("outbound byte lost");

	property p_exp_rd;
		bus_req && !wb_we_i && rg == RG_EXP && pen_reg |=> wb_dat_o == $past(prom_q);
	endproperty
	a_exp_rd: assert property (p_exp_rd) else $error("expansion read wrong");

	property p_prom_on;
		bus_req && rg == RG_SLOTPG |=> pen_reg;
	endproperty
	a_prom_on: assert property (p_prom_on) else $error("prom not enabled");

	property p_prom_off;
		bus_req && rg == RG_EXPOFF |=> !pen_reg ##1 (pen_reg == $past(pen_next));
	endproperty
	a_prom_off: assert property (p_prom_off) else $error("prom not disabled");

	property p_sel_wr;
		wr && rg == RG_CTRL |=> ctl_sel_o == $past(wb_dat_i[7]) &&
		                        ctl_bsy_o == $past(wb_dat_i[6]);
	endproperty
	a_sel_wr: assert property (p_sel_wr) else $error("control write not applied");

	property p_rst_limit;
		ctl_rst_o |-> rcnt_reg < `DHBA_RST_CW'(RST_MAX_CYC);
	endproperty
	a_rst_limit: assert property (p_rst_limit) else $error("reset held too long");

	property p_status;
		bus_req && !wb_we_i && rg == RG_CTRL |=>
			wb_dat_o[2:1] == 2'h3 && wb_dat_o[3] == $past(busy_s) && wb_dat_o[7] == $past(req_s);
	endproperty
	a_status: assert property (p_status) else $error("status layout wrong");

	property p_reset_out;
		$fell(rst_i) |-> !ctl_sel_o && !ctl_bsy_o && !ctl_rst_o && !pen_reg && !ctl_ack_o;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("reset state wrong");

endmodule : dhba_top
`default_nettype wire

// file: tb/dhba_ctl_model.sv
// behavioural disk controller on the far side of the adapter's controller bus
`timescale 1ns/1ps
`default_nettype none

module dhba_ctl_model #(
	parameter logic [7:0] STATUS_VAL = 8'h00, // completion status handed back
	parameter int         CMD_LEN    = 6      // command bytes requested
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sel_i,
	input  wire logic       rst_ctl_i,
	input  wire logic       ack_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            par_o,
	output logic            req_o,
	output logic            cd_o,
	output logic            io_o,
	output logic            msg_o,
	output logic            busy_o
);
	logic [7:0] got_reg [0:9]; // command bytes received
	logic [7:0] drv_reg;       // byte offered to the adapter
	logic       drv_en_reg;    // data lines driven by this side
	int         ph_reg;        // sequence step
	int         idx_reg;       // command byte index

	////////////////////////////////////////////////////////////////////////////////
	// released lines show the inverse of the last byte, so stale data never matches
	assign data_o = drv_en_reg ? drv_reg : ~drv_reg;
	assign par_o  = drv_en_reg ? ~^drv_reg : ^drv_reg;

	////////////////////////////////////////////////////////////////////////////////
	// one operation: select, command bytes, status byte, message byte
	always @(posedge clk_i) begin
		if (rst_i || rst_ctl_i) begin
			{req_o, cd_o, io_o, msg_o, busy_o, drv_en_reg} <= 6'h00;
			drv_reg <= 8'h00; // released lines then read all ones, never unknown
			ph_reg <= 0;
		end else begin
			case (ph_reg)
				0: if (sel_i && data_i[0]) begin
					busy_o <= 1'b1;
					ph_reg <= 1;
				end
				1: if (!sel_i) begin
					idx_reg <= 0;
					ph_reg  <= 2;
				end
				// each byte begins with a request from this side
				2: begin
					{req_o, cd_o, io_o} <= 3'h7;
					ph_reg <= 3;
				end
				3: if (ack_i) begin
					got_reg[idx_reg] <= data_i;
					req_o  <= 1'b0;
					ph_reg <= 4;
				end
				4: if (!ack_i) begin
					idx_reg <= idx_reg + 1;
					ph_reg  <= (idx_reg == CMD_LEN - 1) ? 5 : 2;
				end
				// whole descriptor taken before anything runs; no seek step asked for
				5: begin
					drv_reg    <= STATUS_VAL;
					drv_en_reg <= 1'b1;
					{req_o, io_o} <= 2'h2;
					ph_reg <= 6;
				end
				// lines released once the adapter acknowledges
				6, 8: if (ack_i) begin
					{req_o, drv_en_reg} <= 2'h0;
					ph_reg <= ph_reg + 1;
				end
				7: if (!ack_i) begin
					drv_reg <= 8'h00;
					{req_o, msg_o, drv_en_reg} <= 3'h7;
					ph_reg <= 8;
				end
				9: if (!ack_i) begin
					{busy_o, msg_o, cd_o} <= 3'h0;
					ph_reg <= 0;
				end
				default: ph_reg <= 0;
			endcase
		end
	end
endmodule : dhba_ctl_model

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the disk host bus adapter with a controller model
`timescale 1ns/1ps
`default_nettype none
`include "dhba_map.svh"

module tb;
	localparam int         RST_CYC    = 50;    // shortened reset ceiling
	localparam logic [7:0] CMP_STATUS = 8'h02; // status the model returns
	localparam logic [7:0] SENSE_OPC  = 8'h5A; // arbitrary sense opcode, model ignores it
	logic [7:0]  st;                           // last completion status read
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [7:0]  wb_dat_i = 8'h00;
	logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic [0:0]  wb_sel_i = 1'b1;
	logic [2:0]  slot_num_i = 3'h1;
	logic        prom_load_we_i = 1'b0;
	logic [10:0] prom_load_adr_i = 11'h000;
	logic [7:0]  prom_load_dat_i = 8'h00;
	logic [7:0]  wb_dat_o, ctl_data_o, m_data, rdata;
	logic        wb_ack_o, ctl_data_oe_o, ctl_par_o, ctl_sel_o, ctl_bsy_o, ctl_rst_o, ctl_ack_o;
	logic        ctl_req_i, ctl_cd_i, ctl_io_i, ctl_msg_i, ctl_busy_i, m_par;
	wire logic [7:0] ctl_data_i;  // bus level: adapter wins while it drives
	wire logic       ctl_par_i;
	logic [31:0] rng = 32'h60;    // xorshift state
	logic [15:0] base;            // register window of the strapped slot
	logic [7:0]  img [0:2047];    // expected prom image
	logic [7:0]  cmd [0:5];       // command bytes sent
	int          err_count = 0, cmp_count = 0;

	assign ctl_data_i = ctl_data_oe_o ? ctl_data_o : m_data;
	assign ctl_par_i  = ctl_data_oe_o ? ctl_par_o : m_par;
	always #20 clk_i = ~clk_i;

	dhba_top #(.RST_MAX_CYC(RST_CYC)) uut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
		.wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .slot_num_i, .prom_load_we_i,
		.prom_load_adr_i, .prom_load_dat_i, .ctl_data_i, .ctl_par_i, .ctl_req_i, .ctl_cd_i,
		.ctl_io_i, .ctl_msg_i, .ctl_busy_i, .ctl_data_o, .ctl_data_oe_o, .ctl_par_o,
		.ctl_sel_o, .ctl_bsy_o, .ctl_rst_o, .ctl_ack_o);
	dhba_ctl_model #(.STATUS_VAL(CMP_STATUS), .CMD_LEN(6)) ctl (.clk_i, .rst_i,
		.sel_i(ctl_sel_o), .rst_ctl_i(ctl_rst_o), .ack_i(ctl_ack_o), .data_i(ctl_data_i),
		.data_o(m_data), .par_o(m_par), .req_o(ctl_req_i), .cd_o(ctl_cd_i), .io_o(ctl_io_i),
		.msg_o(ctl_msg_i), .busy_o(ctl_busy_i));

	////////////////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd

	task stop_test();
		$display("mismatches %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// masked compare; x in a checked bit never matches
	task chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
		cmp_count++;
		if ((got & msk) !== (exp & msk)) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// one classic cycle; the answer is awaited, never assumed
	task wb(input logic [15:0] a, input logic we, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdata = wb_dat_o;
		chk({7'h0, n < 20}, 8'h01, 8'h01);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk_i);
		#1;
	endtask : wb

	task rdc(input logic [15:0] a, input logic [7:0] exp);
		wb(a, 1'b0, 8'h00);
		chk(rdata, exp, 8'hFF);
	endtask : rdc

	// poll the status port until the masked bits match
	task poll(input logic [7:0] msk, input logic [7:0] val);
		int n;
		n = 0;
		do begin
			wb(base + 16'h1, 1'b0, 8'h00);
			n++;
		end while ((rdata & msk) !== val && n < 300);
	endtask : poll

	// data-port byte, then the acknowledge must rise; its fall is only waited for, not checked
	task xfer(input logic we, input logic [7:0] d);
		int n;
		wb(base, we, d);
		n = 0;
		while (ctl_ack_o !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			n++;
		end
		chk({7'h0, n < 10}, 8'h01, 8'h01);
		while (ctl_ack_o !== 1'b0 && n < 60) begin
			@(posedge clk_i);
			n++;
		end
	endtask : xfer

	// one command through select, descriptor, status and message bytes
	task op(input logic [7:0] opc);
		int k;
		poll(8'h08, 8'h00);
		wb(base + 16'h1, 1'b1, 8'h80);
		chk({ctl_sel_o, ctl_data_oe_o, ctl_par_o, 5'h0}, 8'hC0, 8'hE0);
		chk(ctl_data_o, 8'h01, 8'hFF);
		poll(8'h08, 8'h08);
		wb(base + 16'h1, 1'b1, 8'h00);
		for (k = 0; k < 6; k++) begin
			poll(8'h80, 8'h80);
			chk(rdata, 8'hEE, 8'hFE);
			cmd[k] = (k == 0) ? opc : 8'(rnd());
			xfer(1'b1, cmd[k]);
		end
		poll(8'h80, 8'h80);
		chk(rdata, 8'hCF, 8'hFF);
		xfer(1'b0, 8'h00);
		chk(rdata, CMP_STATUS, 8'hFF);
		st = rdata;
		poll(8'h80, 8'h80);
		chk(rdata, 8'hDF, 8'hFF);
		xfer(1'b0, 8'h00);
		chk(rdata, 8'h00, 8'hFF);
		for (k = 0; k < 6; k++)
			chk(ctl.got_reg[k], cmd[k], 8'hFF);
		poll(8'h08, 8'h00);
	endtask : op

	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("wrong value at %0t: run hung", $time);
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [7:0] r8;
		logic [10:0] r11;
		logic [15:0] pg;
		slot_num_i = 3'(rnd() % 7 + 1);
		base = `DHBA_DEVSEL_BASE + {9'h0, slot_num_i, 4'h0};
		pg = {5'h18, slot_num_i, 8'h00};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({ctl_sel_o, ctl_bsy_o, ctl_rst_o, ctl_ack_o, ctl_data_oe_o, 3'h0}, 8'h00, 8'hF8);
		wb(base + 16'h1, 1'b0, 8'h00);
		chk(rdata, 8'h06, 8'hFE);
		for (i = 2; i < 16; i++) begin
			wb(base + 16'(i), 1'b1, 8'(rnd()));
			rdc(base + 16'(i), 8'h00);
		end
		rdc(base ^ 16'h0010, 8'h00);
		wb((base ^ 16'h0010) + 16'h1, 1'b1, 8'h80);
		chk({7'h0, ctl_sel_o}, 8'h00, 8'h01);
		for (i = 0; i < 2048; i++) begin
			@(posedge clk_i);
			img[i] = 8'(rnd());
			prom_load_we_i <= 1'b1;
			prom_load_adr_i <= 11'(i);
			prom_load_dat_i <= img[i];
		end
		@(posedge clk_i);
		prom_load_we_i <= 1'b0;
		rdc(16'hC800, 8'h00);
		for (i = 0; i < 4; i++) begin
			r8 = 8'(rnd());
			rdc(pg | 16'(r8), img[r8]);
			r11 = 11'(rnd() % 2047);
			rdc(16'hC800 + 16'(r11), img[r11]);
		end
		rdc(16'hCFFE, img[2046]);
		wb(16'hCFFF, 1'b1, 8'h00);
		rdc(16'hC800, 8'h00);
		wb(pg | 16'h0010, 1'b1, 8'h00);
		rdc(16'hC801, img[1]);
		// the reset bit must clear itself within the ceiling
		wb(base + 16'h1, 1'b1, 8'h20);
		chk({7'h0, ctl_rst_o}, 8'h01, 8'h01);
		i = 0;
		while (ctl_rst_o === 1'b1 && i < 200) begin
			@(posedge clk_i);
			i++;
		end
		chk({7'h0, i <= RST_CYC && i >= RST_CYC - 6}, 8'h01, 8'h01);
		// a command with no data phase, so no buffer address is set up
		op(8'(rnd()));
		// an error status is followed by a sense command
		if (st != 8'h00)
			op(SENSE_OPC);
		// a data write with no request pending gets no acknowledge
		wb(base, 1'b1, 8'(rnd()));
		repeat (4) @(posedge clk_i);
		chk({7'h0, ctl_ack_o}, 8'h00, 8'h01);
		// reset in mid-run with outputs raised and the prom enabled
		wb(base + 16'h1, 1'b1, 8'h60);
		rdc(pg, img[0]);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({ctl_sel_o, ctl_bsy_o, ctl_rst_o, ctl_ack_o, ctl_par_o, 3'h0}, 8'h08, 8'hF8);
		rdc(16'hC800, 8'h00);
		stop_test();
	end
endmodule : tb

`default_nettype wire
